// File: verilog/partition_id_regs.sv
/*
  Read-only identification register bank seen through a Secure and a Non-secure frame.
  Assumes a simple synchronous read/write port; a frame select picks the requesting frame.
*/
`timescale 1ns/1ns
module partition_id_regs (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_secure,
  input  wire logic [11:0] req_offset,
  input  wire logic [31:0] req_wdata,
  output logic      [31:0] rd_data_q,
  output logic             rd_valid_q,
  input  wire logic [partition_id_pkg::CAP_WD_MSB:0]  s_capacity_fraction_width,
  input  wire logic [partition_id_pkg::PORT_WD_MSB:0] s_portion_bitmap_width,
  input  wire logic [partition_id_pkg::MON_CNT_MSB:0] s_storage_monitor_count,
  input  wire logic [partition_id_pkg::CAP_WD_MSB:0]  ns_capacity_fraction_width,
  input  wire logic [partition_id_pkg::PORT_WD_MSB:0] ns_portion_bitmap_width,
  input  wire logic [partition_id_pkg::MON_CNT_MSB:0] ns_storage_monitor_count,
  input  wire logic        capture_supported,
  input  wire logic        capacity_feature_flag,
  input  wire logic        portion_feature_flag,
  input  wire logic        monitoring_feature_flag,
  input  wire logic        storage_usage_monitor,
  output logic      [10:0] s_bitmap_regs,
  output logic      [10:0] ns_bitmap_regs
);
  import partition_id_pkg::*;

  logic [31:0] cap_w  [NUM_FRAMES];
  logic [31:0] por_w  [NUM_FRAMES];
  logic [31:0] sto_w  [NUM_FRAMES];
  logic [10:0] regs_w [NUM_FRAMES];
  logic [31:0] arch_word;
  logic [31:0] rd_data_d;
  logic        frame_idx;
  logic [15:0] bmp_width [NUM_FRAMES];
  logic [31:0] bmp_bits  [NUM_FRAMES];
  logic [31:0] bmp_span  [NUM_FRAMES];
  logic [CAP_WD_MSB:0] cap_strap [NUM_FRAMES];

  // Index 0 is the Secure frame, index 1 the Non-secure frame.
  frame_id_values u_sec (
    .capacity_fraction_width (s_capacity_fraction_width),
    .portion_bitmap_width    (s_portion_bitmap_width),
    .storage_monitor_count   (s_storage_monitor_count),
    .capture_supported       (capture_supported),
    .capacity_feature_flag   (capacity_feature_flag),
    .portion_feature_flag    (portion_feature_flag),
    .monitoring_feature_flag (monitoring_feature_flag),
    .storage_usage_monitor   (storage_usage_monitor),
    .capacity_word           (cap_w[0]),
    .portion_word            (por_w[0]),
    .storage_word            (sto_w[0]),
    .bitmap_regs             (regs_w[0])
  );
  frame_id_values u_nsec (
    .capacity_fraction_width (ns_capacity_fraction_width),
    .portion_bitmap_width    (ns_portion_bitmap_width),
    .storage_monitor_count   (ns_storage_monitor_count),
    .capture_supported       (capture_supported),
    .capacity_feature_flag   (capacity_feature_flag),
    .portion_feature_flag    (portion_feature_flag),
    .monitoring_feature_flag (monitoring_feature_flag),
    .storage_usage_monitor   (storage_usage_monitor),
    .capacity_word           (cap_w[1]),
    .portion_word            (por_w[1]),
    .storage_word            (sto_w[1]),
    .bitmap_regs             (regs_w[1])
  );

  assign s_bitmap_regs  = regs_w[0];
  assign ns_bitmap_regs = regs_w[1];
  assign frame_idx      = ~req_secure;
  assign arch_word      = {24'h00_0000, ARCH_MAJOR, ARCH_MINOR};
  assign bmp_width[0]   = s_portion_bitmap_width;
  assign bmp_width[1]   = ns_portion_bitmap_width;
  assign cap_strap[0]   = s_capacity_fraction_width;
  assign cap_strap[1]   = ns_capacity_fraction_width;

  // Writes select nothing, so every register keeps its value and a write has no answer data.
  always_comb begin
    rd_data_d = 32'h0000_0000;
    if (req_valid && !req_write) begin
      unique case (req_offset)
        OFS_ARCH_REV:    rd_data_d = arch_word;
        OFS_PORTION:     rd_data_d = por_w[frame_idx];
        OFS_CAPACITY:    rd_data_d = cap_w[frame_idx];
        OFS_STORAGE_MON: rd_data_d = sto_w[frame_idx];
        default:         rd_data_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_q <= RDATA_RESET;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= req_valid;
    end
  end

  // Answers are checked one cycle after the request because the read port is registered.
  AST_ARCH_SAME: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && !req_write && req_offset == OFS_ARCH_REV
    |=> rd_data_q == 32'h0000_0010)
    else $error("architecture word wrong");
  AST_ARCH_RESERVED: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && !req_write && req_offset == OFS_ARCH_REV |=> rd_data_q[31:8] == 0)
    else $error("architecture reserved bits set");
  AST_CAP_ABSENT: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req_offset == OFS_CAPACITY && !capacity_feature_flag |=> rd_data_q == 0)
    else $error("absent capacity register not zero");
  AST_POR_ABSENT: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req_offset == OFS_PORTION && !portion_feature_flag |=> rd_data_q == 0)
    else $error("absent portion register not zero");
  AST_STO_ABSENT: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req_offset == OFS_STORAGE_MON && !(monitoring_feature_flag
    && storage_usage_monitor) |=> rd_data_q == 0)
    else $error("absent storage register not zero");

  AST_CAP_FIELD: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && !req_write && req_offset == OFS_CAPACITY && capacity_feature_flag
    |=> rd_data_q[31:6] == 0 && rd_data_q[5:0] == ($past(req_secure)
    ? $past(s_capacity_fraction_width) : $past(ns_capacity_fraction_width)))
    else $error("capacity field wrong");
  AST_CAP_RANGE: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && !req_write && req_offset == OFS_CAPACITY && capacity_feature_flag
    |=> rd_data_q[5:0] >= 6'h01 && rd_data_q[5:0] <= 6'h10)
    else $error("capacity fraction width out of range");
  AST_POR_FIELD: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && !req_write && req_offset == OFS_PORTION && portion_feature_flag
    |=> rd_data_q[31:16] == 0 && rd_data_q[15:0] == ($past(req_secure)
    ? $past(s_portion_bitmap_width) : $past(ns_portion_bitmap_width)))
    else $error("portion field wrong");
  AST_POR_RANGE: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && !req_write && req_offset == OFS_PORTION && portion_feature_flag
    |=> rd_data_q[15:0] <= 16'h8000)
    else $error("portion bitmap width out of range");
  AST_STO_FIELD: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && !req_write && req_offset == OFS_STORAGE_MON && monitoring_feature_flag
    && storage_usage_monitor |=> rd_data_q[31] == $past(capture_supported)
    && rd_data_q[30:16] == 0)
    else $error("storage word wrong");
  AST_STO_COUNT: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && !req_write && req_offset == OFS_STORAGE_MON && monitoring_feature_flag
    && storage_usage_monitor |=> rd_data_q[15:0] == ($past(req_secure)
    ? $past(s_storage_monitor_count) : $past(ns_storage_monitor_count)))
    else $error("storage monitor count wrong");
  AST_STO_CAPT_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && !req_write && req_offset == OFS_STORAGE_MON && !capture_supported
    |=> !rd_data_q[31])
    else $error("capture bit set without capture support");

  AST_WRITE_NO_DATA: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req_write |=> rd_valid_q && rd_data_q == 0)
    else $error("write returned data");
  AST_WDATA_IGNORED: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req_write && req_wdata != 32'h0000_0000 |=> rd_data_q == 0)
    else $error("write data reached the read port");
  AST_ANSWER_VALID: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid |=> rd_valid_q)
    else $error("access not answered");
  AST_IDLE_QUIET: assert property (@(posedge mclk) disable iff (!reset_n)
    !req_valid |=> !rd_valid_q && rd_data_q == 0)
    else $error("answer without an access");
  AST_BITMAP_REGS: assert property (@(posedge mclk) disable iff (!reset_n)
    portion_feature_flag && s_portion_bitmap_width == 16'h0021 |-> s_bitmap_regs == 2)
    else $error("bitmap register count wrong");
  AST_UNMAPPED: assert property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req_offset == 12'h024 |=> rd_data_q == 0)
    else $error("unmapped offset not zero");

  // Width zero stands for the largest bitmap; the span is checked on bit counts, not slices.
  for (genvar g = 0; g < NUM_FRAMES; g++) begin : g_frame_check
    assign bmp_bits[g] = (bmp_width[g] == 16'h0000) ? 32'h0000_8000
                         : {16'h0000, bmp_width[g]};
    assign bmp_span[g] = {21'h00_0000, regs_w[g]} * BITMAP_WORD;
    AST_BITMAP_SPAN: assert property (@(posedge mclk) disable iff (!reset_n)
      portion_feature_flag |-> bmp_span[g] >= bmp_bits[g]
      && bmp_span[g] < bmp_bits[g] + BITMAP_WORD)
      else $error("bitmap register count does not cover the width");
    AST_BITMAP_MAX: assert property (@(posedge mclk) disable iff (!reset_n)
      regs_w[g] <= BITMAP_MAX_REGS)
      else $error("bitmap register count above the limit");
    AST_BITMAP_ABSENT: assert property (@(posedge mclk) disable iff (!reset_n)
      !portion_feature_flag |-> regs_w[g] == 11'h000)
      else $error("bitmap registers reported without the feature");
    AST_WORD_RESERVED: assert property (@(posedge mclk) disable iff (!reset_n)
      cap_w[g][31:6] == 0 && por_w[g][31:16] == 0 && sto_w[g][30:16] == 0)
      else $error("reserved bits set in a frame word");
    AST_WORD_ABSENT: assert property (@(posedge mclk) disable iff (!reset_n)
      (capacity_feature_flag || cap_w[g] == 0) && (portion_feature_flag || por_w[g] == 0)
      && ((monitoring_feature_flag && storage_usage_monitor) || sto_w[g] == 0))
      else $error("absent register word not zero in a frame");
    AST_WORD_PRESENT: assert property (@(posedge mclk) disable iff (!reset_n)
      capacity_feature_flag && portion_feature_flag |-> cap_w[g][5:0] == cap_strap[g]
      && por_w[g][15:0] == bmp_width[g])
      else $error("frame word does not describe its own frame");
  end

  COV_ARCH_NS: cover property (@(posedge mclk) disable iff (!reset_n)
    req_valid && !req_secure && req_offset == OFS_ARCH_REV);
  COV_CAP_S: cover property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req_secure && req_offset == OFS_CAPACITY && capacity_feature_flag);
  COV_STO_CAPT: cover property (@(posedge mclk) disable iff (!reset_n)
    req_valid && req_offset == OFS_STORAGE_MON && capture_supported);
  COV_WRITE: cover property (@(posedge mclk) disable iff (!reset_n) req_valid && req_write);
  COV_BITMAP_MAX: cover property (@(posedge mclk) disable iff (!reset_n)
    ns_bitmap_regs == 11'h400);
endmodule : partition_id_regs

// File: verilog/partition_id_pkg.sv
/*
  Constants for the resource partition identification register bank.
  Assumes a 32-bit word-addressed read port with byte offsets inside one feature frame.
*/
package partition_id_pkg;
  localparam logic [11:0] OFS_ARCH_REV    = 12'h020;
  localparam logic [11:0] OFS_PORTION     = 12'h030;
  localparam logic [11:0] OFS_CAPACITY    = 12'h038;
  localparam logic [11:0] OFS_STORAGE_MON = 12'h088;
  localparam logic [3:0]  ARCH_MAJOR      = 4'h1;
  localparam logic [3:0]  ARCH_MINOR      = 4'h0;
  localparam int          CAP_WD_MSB      = 5;
  localparam int          PORT_WD_MSB     = 15;
  localparam int          MON_CNT_MSB     = 15;
  localparam int          CAPTURE_BIT     = 31;
  localparam int          BITMAP_WORD     = 32;
  localparam int          BITMAP_MAX_REGS = 1024;
  localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;
  localparam int          NUM_FRAMES      = 2;
endpackage : partition_id_pkg

// File: verilog/frame_id_values.sv
/*
  Per-frame identification value former for one feature frame.
  Assumes the feature settings of its frame are static straps from the integration.
*/
`timescale 1ns/1ns
module frame_id_values (
  input  wire logic [partition_id_pkg::CAP_WD_MSB:0]  capacity_fraction_width,
  input  wire logic [partition_id_pkg::PORT_WD_MSB:0] portion_bitmap_width,
  input  wire logic [partition_id_pkg::MON_CNT_MSB:0] storage_monitor_count,
  input  wire logic                                   capture_supported,
  input  wire logic                                   capacity_feature_flag,
  input  wire logic                                   portion_feature_flag,
  input  wire logic                                   monitoring_feature_flag,
  input  wire logic                                   storage_usage_monitor,
  output logic      [31:0]                            capacity_word,
  output logic      [31:0]                            portion_word,
  output logic      [31:0]                            storage_word,
  output logic      [10:0]                            bitmap_regs
);
  import partition_id_pkg::*;

  logic storage_present;
  logic [14:0] width_m1;

  // Both monitoring flags gate the storage register, not either one alone.
  assign storage_present = monitoring_feature_flag & storage_usage_monitor;

  always_comb begin
    capacity_word = 32'h0000_0000;
    portion_word  = 32'h0000_0000;
    storage_word  = 32'h0000_0000;
    if (capacity_feature_flag) begin
      capacity_word[CAP_WD_MSB:0] = capacity_fraction_width;
    end
    if (portion_feature_flag) begin
      portion_word[PORT_WD_MSB:0] = portion_bitmap_width;
    end
    if (storage_present) begin
      storage_word[MON_CNT_MSB:0] = storage_monitor_count;
      storage_word[CAPTURE_BIT]   = capture_supported;
    end
  end

  // Widths 0 and 32768 share bits [14:0], so both wrap to 32767 and give 1024 registers.
  assign width_m1    = portion_bitmap_width[14:0] - 15'h0001;
  assign bitmap_regs = portion_feature_flag ? {1'b0, width_m1[14:5]} + 11'h001 : 11'h000;
endmodule : frame_id_values

// File: dv/tb.sv
/*
  Self-checking bench for the identification register bank; drives its ports directly.
  Assumes the bank answers every access exactly one cycle after it is taken.
*/
`timescale 1ns/1ns
module tb;
  import partition_id_pkg::*;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        req_valid = 1'b0, req_write = 1'b0, req_secure = 1'b0;
  logic [11:0] req_offset = 12'h000;
  logic [31:0] req_wdata = 32'h0000_0000, rd_data_q;
  logic        rd_valid_q;
  logic [5:0]  s_cap = 6'h10, ns_cap = 6'h01;
  logic [15:0] s_por = 16'h0021, ns_por = 16'h0020, s_mon = 16'hFFFF, ns_mon = 16'h0003;
  logic        capt = 1'b1, f_cap = 1'b1, f_por = 1'b1, f_mon = 1'b1, f_csu = 1'b1;
  logic [10:0] s_regs, ns_regs;
  int          n_fail = 0;
  int          samples_checked = 0;

  always #20 mclk = ~mclk;

  partition_id_regs dut_u (.mclk(mclk), .reset_n(reset_n), .req_valid(req_valid),
    .req_write(req_write), .req_secure(req_secure), .req_offset(req_offset),
    .req_wdata(req_wdata), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .s_capacity_fraction_width(s_cap), .s_portion_bitmap_width(s_por),
    .s_storage_monitor_count(s_mon), .ns_capacity_fraction_width(ns_cap),
    .ns_portion_bitmap_width(ns_por), .ns_storage_monitor_count(ns_mon),
    .capture_supported(capt), .capacity_feature_flag(f_cap), .portion_feature_flag(f_por),
    .monitoring_feature_flag(f_mon), .storage_usage_monitor(f_csu),
    .s_bitmap_regs(s_regs), .ns_bitmap_regs(ns_regs));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One access from a falling edge; the answer is looked at in its single cycle.
  task automatic acc(input logic wr, input logic sec, input logic [11:0] ofs,
                     input logic [31:0] exp);
    chk({31'h0, rd_valid_q}, 32'h0, "idle valid");
    req_valid = 1'b1; req_write = wr; req_secure = sec; req_offset = ofs;
    req_wdata = 32'hFFFF_FFFF;
    @(negedge mclk);
    chk({31'h0, rd_valid_q}, 32'h1, "answer valid");
    chk(rd_data_q, exp, "answer data");
    req_valid = 1'b0;
    @(negedge mclk);
  endtask : acc

  task automatic t_arch;
    acc(1'b0, 1'b1, OFS_ARCH_REV, 32'h0000_0010);
    acc(1'b0, 1'b0, OFS_ARCH_REV, 32'h0000_0010);
    $display("test arch done");
  endtask : t_arch

  task automatic t_present;
    acc(1'b0, 1'b1, OFS_CAPACITY, 32'h0000_0010);
    acc(1'b0, 1'b0, OFS_CAPACITY, 32'h0000_0001);
    acc(1'b0, 1'b1, OFS_PORTION, 32'h0000_0021);
    acc(1'b0, 1'b0, OFS_PORTION, 32'h0000_0020);
    acc(1'b0, 1'b1, OFS_STORAGE_MON, 32'h8000_FFFF);
    acc(1'b0, 1'b0, OFS_STORAGE_MON, 32'h8000_0003);
    chk({21'h0, s_regs}, 32'h2, "s bitmap regs");
    chk({21'h0, ns_regs}, 32'h1, "ns bitmap regs");
    ns_por = 16'h0000;
    #1 chk({21'h0, ns_regs}, 32'h0000_0400, "max bitmap regs");
    capt = 1'b0;
    acc(1'b0, 1'b0, OFS_STORAGE_MON, 32'h0000_0003);
    $display("test present done");
  endtask : t_present

  task automatic t_absent;
    f_cap = 1'b0; f_por = 1'b0; f_csu = 1'b0;
    acc(1'b0, 1'b1, OFS_CAPACITY, 32'h0000_0000);
    acc(1'b0, 1'b0, OFS_PORTION, 32'h0000_0000);
    acc(1'b0, 1'b1, OFS_STORAGE_MON, 32'h0000_0000);
    chk({21'h0, s_regs}, 32'h0, "absent bitmap regs");
    f_mon = 1'b0; f_csu = 1'b1;
    acc(1'b0, 1'b0, OFS_STORAGE_MON, 32'h0000_0000);
    acc(1'b0, 1'b1, OFS_ARCH_REV, 32'h0000_0010);
    f_cap = 1'b1; f_por = 1'b1; f_mon = 1'b1; capt = 1'b1;
    $display("test absent done");
  endtask : t_absent

  task automatic t_write;
    acc(1'b1, 1'b1, OFS_ARCH_REV, 32'h0000_0000);
    acc(1'b1, 1'b0, OFS_CAPACITY, 32'h0000_0000);
    acc(1'b1, 1'b1, OFS_STORAGE_MON, 32'h0000_0000);
    acc(1'b0, 1'b1, OFS_ARCH_REV, 32'h0000_0010);
    acc(1'b0, 1'b0, OFS_CAPACITY, 32'h0000_0001);
    acc(1'b0, 1'b1, OFS_STORAGE_MON, 32'h8000_FFFF);
    acc(1'b0, 1'b0, 12'h024, 32'h0000_0000);
    $display("test write done");
  endtask : t_write

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // A hung run is cut short here and counted as a mismatch.
  initial begin
    #200000;
    n_fail++;
    $display("BAD t=%0t run limit reached", $time);
    test_done();
  end

  initial begin
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    t_arch();
    t_present();
    t_absent();
    t_write();
    test_done();
  end
endmodule : tb
